// ---- fls_field_fmt.sv ----
`timescale 1ns/100ps
module fls_field_fmt (
  fls_fields_if.fmt f
);

  logic       link_up;
  logic [3:0] phys_code;
  logic [3:0] log_code;

  // Out-of-range state codes are reported as Ethernet zero rather than leak.
  assign link_up   = f.link_type && (f.phys_raw == fls_pkg::PHYS_LINK_UP);
  assign phys_code = (f.link_type && f.phys_raw <= fls_pkg::PHYS_MAX) ?
                     f.phys_raw : fls_pkg::PHYS_ETHERNET;
  assign log_code  = (f.link_type && f.log_raw <= fls_pkg::LOG_MAX) ?
                     f.log_raw : fls_pkg::LOG_ETHERNET;

  assign f.act_w    = link_up ? {4'h0, f.act_w_raw} : 8'h00;
  assign f.sup_w    = f.link_type ? {4'h0, f.sup_w_raw} : 8'h00;
  assign f.ltype    = {7'h00, f.link_type};
  assign f.phys_log = {phys_code, log_code};
  assign f.act_s    = link_up ? f.act_s_raw : 8'h00;
  assign f.sup_s    = f.link_type ? f.sup_s_raw : 8'h00;

endmodule : fls_field_fmt

// ---- fls_fields_if.sv ----
`timescale 1ns/100ps
interface fls_fields_if;
  logic       link_type;
  logic [3:0] phys_raw;
  logic [3:0] log_raw;
  logic [3:0] act_w_raw;
  logic [3:0] sup_w_raw;
  logic [7:0] act_s_raw;
  logic [7:0] sup_s_raw;
  logic [7:0] act_w;
  logic [7:0] sup_w;
  logic [7:0] ltype;
  logic [7:0] phys_log;
  logic [7:0] act_s;
  logic [7:0] sup_s;

  modport fmt (
    input  link_type, phys_raw, log_raw, act_w_raw, sup_w_raw, act_s_raw, sup_s_raw,
    output act_w, sup_w, ltype, phys_log, act_s, sup_s
  );
  modport user (
    output link_type, phys_raw, log_raw, act_w_raw, sup_w_raw, act_s_raw, sup_s_raw,
    input  act_w, sup_w, ltype, phys_log, act_s, sup_s
  );
endinterface : fls_fields_if

// ---- fls_mc_model.sv ----
`timescale 1ns/100ps
module fls_mc_model #(
  parameter int REQ_LEN = 46
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RQ_READY,
  input  wire logic       RS_VALID,
  input  wire logic [7:0] RS_DATA,
  input  wire logic [5:0] RS_INDEX,
  output logic            RQ_VALID,
  output logic [7:0]      RQ_DATA,
  output logic            RQ_LAST,
  output logic            RQ_CSUM_ERR,
  output logic            RQ_ID_ERR,
  output logic            RS_READY
);
  logic [7:0] rsp [0:63];
  int         n;
  logic       slow;
  logic       hung;
  initial begin
    RQ_VALID = 1'b0;
    RQ_DATA = 8'h00;
    RQ_LAST = 1'b0;
    RQ_CSUM_ERR = 1'b0;
    RQ_ID_ERR = 1'b0;
    RS_READY = 1'b1;
    slow = 1'b0;
    hung = 1'b0;
    n = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Slow mode stalls every other cycle so the reply must hold its byte.
  always @(posedge CLK_SYS) begin
    if (RS_VALID && RS_READY) begin
      rsp[RS_INDEX] = RS_DATA;
      n = n + 1;
    end
    RS_READY <= slow ? ~RS_READY : 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Call right after a rising edge; the released data line shows the inverse.
  task automatic send(input logic [7:0] ctype, input logic csum, input logic id);
    int   w;
    n = 0;
    for (int i = 0; i < REQ_LEN; i++) begin
      RQ_VALID    <= 1'b1;
      RQ_DATA     <= (i == 4) ? ctype : 8'(i);
      RQ_LAST     <= (i == REQ_LEN - 1);
      RQ_CSUM_ERR <= csum && (i == REQ_LEN - 1);
      RQ_ID_ERR   <= id && (i == REQ_LEN - 1);
      w = 0;
      #1;
      // Ready is looked at a step after each edge so a late grant is not missed.
      while (!RQ_READY && w < 100) begin
        @(posedge CLK_SYS);
        #1;
        w++;
      end
      if (!RQ_READY) hung = 1'b1;
      @(posedge CLK_SYS);
    end
    RQ_VALID    <= 1'b0;
    RQ_DATA     <= ~RQ_DATA;
    RQ_LAST     <= 1'b0;
    RQ_CSUM_ERR <= 1'b0;
    RQ_ID_ERR   <= 1'b0;
  endtask : send
endmodule : fls_mc_model

// ---- fls_monitor.sv ----
`timescale 1ns/100ps
module fls_monitor (
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire logic       RQ_VALID,
  input wire logic       RQ_LAST,
  input wire logic       RQ_CSUM_ERR,
  input wire logic       RQ_ID_ERR,
  input wire logic       RQ_READY,
  input wire logic       RS_VALID,
  input wire logic [7:0] RS_DATA,
  input wire logic [5:0] RS_INDEX,
  input wire logic       RS_LAST,
  input wire logic [7:0] RS_TYPE,
  input wire logic       RS_READY
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  sequence s_take;
    RS_VALID && RS_READY;
  endsequence
  sequence s_bad_end;
    RQ_VALID && RQ_READY && RQ_LAST && (RQ_CSUM_ERR || RQ_ID_ERR);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_TYPE: assert property (RS_VALID |-> RS_TYPE == 8'hB8)
    else $error("Reply type wrong.");
  AST_NOREPLY: assert property (s_bad_end |=> !RS_VALID [*5])
    else $error("Faulty request answered.");
  AST_BUSY: assert property (RS_VALID |-> !RQ_READY)
    else $error("Request taken while replying.");
  AST_FIRST: assert property ($rose(RS_VALID) |-> RS_INDEX == 6'h10)
    else $error("Reply starts at wrong byte.");
  AST_SEQ: assert property (s_take ##0 !RS_LAST |=> RS_VALID && RS_INDEX == $past(RS_INDEX) + 6'h01)
    else $error("Reply byte order broken.");
  AST_END: assert property (s_take ##0 RS_LAST |=> !RS_VALID && RQ_READY)
    else $error("Reply does not end after last byte.");
  AST_LASTF: assert property (RS_LAST == (RS_VALID && RS_INDEX == 6'h23))
    else $error("Last flag wrong.");
  AST_HOLD: assert property (RS_VALID && !RS_READY |=> RS_VALID && $stable(RS_DATA) && $stable(RS_INDEX))
    else $error("Reply byte changed while stalled.");
  AST_ZERO: assert property (RS_VALID && (RS_INDEX inside {[6'h10:6'h1B], 6'h20, 6'h22}) |-> RS_DATA == 8'h00)
    else $error("Zero byte not zero.");
  AST_WRES: assert property (RS_VALID && (RS_INDEX inside {6'h1C, 6'h1D}) |-> RS_DATA[7:4] == 4'h0)
    else $error("Width reserved bits set.");
  AST_LTYPE: assert property (RS_VALID && RS_INDEX == 6'h1E |-> RS_DATA[7:1] == 7'h00)
    else $error("Link type reserved bits set.");
endmodule : fls_monitor

bind fls_query fls_monitor i_fls_monitor (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .RQ_VALID(RQ_VALID), .RQ_LAST(RQ_LAST),
  .RQ_CSUM_ERR(RQ_CSUM_ERR), .RQ_ID_ERR(RQ_ID_ERR), .RQ_READY(RQ_READY),
  .RS_VALID(RS_VALID), .RS_DATA(RS_DATA), .RS_INDEX(RS_INDEX), .RS_LAST(RS_LAST),
  .RS_TYPE(RS_TYPE), .RS_READY(RS_READY)
);

// ---- fls_pkg.sv ----
// Contract
// - Query request carries command type 0x38.
// - Reply is marked with response type 0xB8.
// - Query answered only when fabric type supported.
// - Always answer unless checksum or identifier fault; the code also stays silent while control bit CTRL_CAP_BIT is clear.
// - Response fields sit in bytes 16 to 35.
// - Active width one-hot only when fabric and up.
// - Supported widths mask when fabric, else zero.
// - Link type bit 0: Ethernet zero, fabric one.
// - Physical state codes 0x0 to 0x7.
// - Logical state codes 0x0 to 0x4.
// - Active speed only when fabric and up.
// - Supported speeds mask when fabric, else zero.
package fls_pkg;

  localparam logic [7:0] CMD_LINK_QUERY  = 8'h38;
  localparam logic [7:0] RSP_LINK_QUERY  = 8'hB8;
  localparam logic [15:0] RSP_CODE_OK    = 16'h0000;
  localparam logic [15:0] RSN_CODE_NONE  = 16'h0000;

  localparam int          REQ_TYPE_POS   = 4;
  localparam int          REQ_LEN        = 46;
  localparam logic [5:0]  RSP_FIRST_IDX  = 6'h10;
  localparam logic [5:0]  RSP_LAST_IDX   = 6'h23;
  localparam logic [5:0]  RSP_WIDTH_IDX  = 6'h1C;
  localparam logic [5:0]  RSP_SPEED_IDX  = 6'h20;

  localparam logic [3:0]  PHYS_ETHERNET  = 4'h0;
  localparam logic [3:0]  PHYS_LINK_UP   = 4'h5;
  localparam logic [3:0]  PHYS_MAX       = 4'h7;
  localparam logic [3:0]  LOG_ETHERNET   = 4'h0;
  localparam logic [3:0]  LOG_MAX        = 4'h4;

  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_SUP_WIDTH = 8'h04;
  localparam logic [7:0]  ADDR_SUP_SPEED = 8'h08;
  localparam logic [7:0]  ADDR_COUNTS    = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;

  localparam int          CTRL_LTYPE_BIT = 0;
  localparam int          CTRL_CAP_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h2;
  localparam logic [3:0]  SUP_WIDTH_RST  = 4'hF;
  localparam logic [7:0]  SUP_SPEED_RST  = 8'hFF;

  typedef enum logic [0:0] {
    ST_RECV,
    ST_SEND
  } fls_state_e;

endpackage : fls_pkg

// ---- fls_query.sv ----
`timescale 1ns/100ps
module fls_query #(
  parameter int REQ_LEN = fls_pkg::REQ_LEN
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_N,
  input  wire logic       RQ_VALID,
  input  wire logic [7:0] RQ_DATA,
  input  wire logic       RQ_LAST,
  input  wire logic       RQ_CSUM_ERR,
  input  wire logic       RQ_ID_ERR,
  output logic            RQ_READY,
  output logic            RS_VALID,
  output logic [7:0]      RS_DATA,
  output logic [5:0]      RS_INDEX,
  output logic            RS_LAST,
  output logic [7:0]      RS_TYPE,
  input  wire logic       RS_READY,
  input  wire logic [3:0] PHYS_STATE,
  input  wire logic [3:0] LOG_STATE,
  input  wire logic [3:0] ACT_LANE_WIDTH,
  input  wire logic [7:0] ACT_SPEED_GRADE,
  input  wire logic [7:0] ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic       WR_STB,
  input  wire logic       RD_STB,
  output logic [31:0]     RD_DATA
);

  ////////////////////////////////////////////////////////////////////////////

  if (REQ_LEN < fls_pkg::REQ_TYPE_POS + 1 || REQ_LEN > 63) begin : g_len_check
    $error("REQ_LEN out of range.");
  end

  localparam logic [5:0] TYPE_POS = 6'(fls_pkg::REQ_TYPE_POS);
  localparam logic [5:0] LEN_MAX  = 6'(REQ_LEN - 1);

  fls_pkg::fls_state_e state_reg;

  logic [1:0]  ctrl_reg;
  logic [3:0]  sup_width_reg;
  logic [7:0]  sup_speed_reg;
  logic [31:0] rd_data_reg;

  logic [5:0]  rx_idx_reg;
  logic [7:0]  rx_type_reg;
  logic        type_seen_reg;
  logic [7:0]  last_type_reg;

  logic [5:0]  tx_idx_reg;
  logic [5:0]  tx_idx_next;
  logic [7:0]  tx_data_reg;
  logic [7:0]  rs_type_reg;

  logic [7:0]  snap_act_w_reg;
  logic [7:0]  snap_sup_w_reg;
  logic [7:0]  snap_ltype_reg;
  logic [7:0]  snap_phys_log_reg;
  logic [7:0]  snap_act_s_reg;
  logic [7:0]  snap_sup_s_reg;

  logic [7:0]  cnt_answer_reg;
  logic [7:0]  cnt_csum_reg;
  logic [7:0]  cnt_id_reg;
  logic [7:0]  cnt_skip_reg;

  logic        rx_take;
  logic        rx_end;
  logic        is_query;
  logic        fault_csum;
  logic        fault_id;
  logic        accept;
  logic        skip;
  logic        tx_take;
  logic        tx_done;
  logic        cnt_clear;
  logic        type_now;
  logic [7:0]  type_cur;

  fls_fields_if fields ();

  ////////////////////////////////////////////////////////////////////////////
  // Field formatting from live port state and configuration.

  assign fields.link_type = ctrl_reg[fls_pkg::CTRL_LTYPE_BIT];
  assign fields.phys_raw  = PHYS_STATE;
  assign fields.log_raw   = LOG_STATE;
  assign fields.act_w_raw = ACT_LANE_WIDTH;
  assign fields.sup_w_raw = sup_width_reg;
  assign fields.act_s_raw = ACT_SPEED_GRADE;
  assign fields.sup_s_raw = sup_speed_reg;

  fls_field_fmt u_fmt (
    .f (fields.fmt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request decode.

  assign RQ_READY   = (state_reg == fls_pkg::ST_RECV);
  assign rx_take    = RQ_VALID && RQ_READY;
  // The byte at the nominal length ends the request as if it were marked last.
  assign rx_end     = rx_take && (RQ_LAST || rx_idx_reg == LEN_MAX);

  // The type byte may be the final byte, so the live byte is decoded as well.
  assign type_now   = rx_take && (rx_idx_reg == TYPE_POS);
  assign type_cur   = type_now ? RQ_DATA : rx_type_reg;
  assign is_query   = (type_seen_reg || type_now)
                   && (type_cur == fls_pkg::CMD_LINK_QUERY);
  assign fault_csum = RQ_CSUM_ERR;
  assign fault_id   = RQ_ID_ERR;

  // A fault on a request of any type is counted; only a clean query answers.
  assign accept = rx_end && is_query && !fault_csum && !fault_id
               && ctrl_reg[fls_pkg::CTRL_CAP_BIT];
  assign skip   = rx_end && !fault_csum && !fault_id && !accept;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rx_idx_reg <= 6'h00;
    end else if (rx_end) begin
      rx_idx_reg <= 6'h00;
    end else if (rx_take) begin
      rx_idx_reg <= rx_idx_reg + 6'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rx_type_reg   <= 8'h00;
      type_seen_reg <= 1'b0;
    end else if (rx_end) begin
      type_seen_reg <= 1'b0;
    end else if (rx_take && rx_idx_reg == TYPE_POS) begin
      rx_type_reg   <= RQ_DATA;
      type_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      last_type_reg <= 8'h00;
    end else if (rx_end && (type_seen_reg || type_now)) begin
      last_type_reg <= type_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot so the reply stays coherent while the port state moves on.

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      snap_act_w_reg    <= 8'h00;
      snap_sup_w_reg    <= 8'h00;
      snap_ltype_reg    <= 8'h00;
      snap_phys_log_reg <= 8'h00;
      snap_act_s_reg    <= 8'h00;
      snap_sup_s_reg    <= 8'h00;
    end else if (accept) begin
      snap_act_w_reg    <= fields.act_w;
      snap_sup_w_reg    <= fields.sup_w;
      snap_ltype_reg    <= fields.ltype;
      snap_phys_log_reg <= fields.phys_log;
      snap_act_s_reg    <= fields.act_s;
      snap_sup_s_reg    <= fields.sup_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response byte map.

  function automatic logic [7:0] rsp_byte(input logic [5:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      6'h10:   b = fls_pkg::RSP_CODE_OK[15:8];
      6'h11:   b = fls_pkg::RSP_CODE_OK[7:0];
      6'h12:   b = fls_pkg::RSN_CODE_NONE[15:8];
      6'h13:   b = fls_pkg::RSN_CODE_NONE[7:0];
      6'h1C:   b = snap_act_w_reg;
      6'h1D:   b = snap_sup_w_reg;
      6'h1E:   b = snap_ltype_reg;
      6'h1F:   b = snap_phys_log_reg;
      6'h21:   b = snap_act_s_reg;
      6'h23:   b = snap_sup_s_reg;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : rsp_byte

  ////////////////////////////////////////////////////////////////////////////
  // Response sequencing.

  assign RS_VALID    = (state_reg == fls_pkg::ST_SEND);
  assign tx_take     = RS_VALID && RS_READY;
  assign tx_done     = tx_take && (tx_idx_reg == fls_pkg::RSP_LAST_IDX);
  assign tx_idx_next = tx_idx_reg + 6'h01;

  // One reply at a time: requests are held off until its last byte is taken.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_reg <= fls_pkg::ST_RECV;
    end else begin
      case (state_reg)
        fls_pkg::ST_RECV: begin
          if (accept) begin
            state_reg <= fls_pkg::ST_SEND;
          end
        end
        fls_pkg::ST_SEND: begin
          if (tx_done) begin
            state_reg <= fls_pkg::ST_RECV;
          end
        end
        default: state_reg <= fls_pkg::ST_RECV;
      endcase
    end
  end

  // The next byte is fetched on each take, so RS_DATA is always a flop output.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      tx_idx_reg  <= fls_pkg::RSP_FIRST_IDX;
      tx_data_reg <= 8'h00;
    end else if (accept) begin
      tx_idx_reg  <= fls_pkg::RSP_FIRST_IDX;
      tx_data_reg <= fls_pkg::RSP_CODE_OK[15:8];
    end else if (tx_take && !tx_done) begin
      tx_idx_reg  <= tx_idx_next;
      tx_data_reg <= rsp_byte(tx_idx_next);
    end
  end

  // The reply type stays up after a reply; only reset takes it back to zero.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rs_type_reg <= 8'h00;
    end else if (accept) begin
      rs_type_reg <= fls_pkg::RSP_LINK_QUERY;
    end
  end

  assign RS_DATA  = tx_data_reg;
  assign RS_INDEX = tx_idx_reg;
  assign RS_LAST  = RS_VALID && (tx_idx_reg == fls_pkg::RSP_LAST_IDX);
  assign RS_TYPE  = rs_type_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Event counters; an event in the clearing cycle still counts as one.

  assign cnt_clear = WR_STB && (ADDR == fls_pkg::ADDR_COUNTS);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cnt_answer_reg <= 8'h00;
    end else if (cnt_clear) begin
      cnt_answer_reg <= {7'h00, accept};
    end else if (accept && cnt_answer_reg != 8'hFF) begin
      cnt_answer_reg <= cnt_answer_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cnt_csum_reg <= 8'h00;
    end else if (cnt_clear) begin
      cnt_csum_reg <= {7'h00, rx_end && fault_csum};
    end else if (rx_end && fault_csum && cnt_csum_reg != 8'hFF) begin
      cnt_csum_reg <= cnt_csum_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cnt_id_reg <= 8'h00;
    end else if (cnt_clear) begin
      cnt_id_reg <= {7'h00, rx_end && fault_id};
    end else if (rx_end && fault_id && cnt_id_reg != 8'hFF) begin
      cnt_id_reg <= cnt_id_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cnt_skip_reg <= 8'h00;
    end else if (cnt_clear) begin
      cnt_skip_reg <= {7'h00, skip};
    end else if (skip && cnt_skip_reg != 8'hFF) begin
      cnt_skip_reg <= cnt_skip_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  // Writes to unmapped offsets are dropped; the port never stalls the master.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctrl_reg <= fls_pkg::CTRL_RESET;
    end else if (WR_STB && ADDR == fls_pkg::ADDR_CTRL) begin
      ctrl_reg <= WR_DATA[1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sup_width_reg <= fls_pkg::SUP_WIDTH_RST;
    end else if (WR_STB && ADDR == fls_pkg::ADDR_SUP_WIDTH) begin
      sup_width_reg <= WR_DATA[3:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sup_speed_reg <= fls_pkg::SUP_SPEED_RST;
    end else if (WR_STB && ADDR == fls_pkg::ADDR_SUP_SPEED) begin
      sup_speed_reg <= WR_DATA[7:0];
    end
  end

  // Read data stand for the cycle after each cycle of read strobe and return to zero otherwise.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (RD_STB) begin
      case (ADDR)
        fls_pkg::ADDR_CTRL:      rd_data_reg <= {30'h0, ctrl_reg};
        fls_pkg::ADDR_SUP_WIDTH: rd_data_reg <= {28'h0, sup_width_reg};
        fls_pkg::ADDR_SUP_SPEED: rd_data_reg <= {24'h0, sup_speed_reg};
        fls_pkg::ADDR_COUNTS:    rd_data_reg <= {cnt_skip_reg, cnt_id_reg,
                                                 cnt_csum_reg, cnt_answer_reg};
        fls_pkg::ADDR_STATUS:    rd_data_reg <= {16'h0, last_type_reg,
                                                 7'h00, RS_VALID};
        default:                 rd_data_reg <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_reg <= 32'h0000_0000;
    end
  end

  assign RD_DATA = rd_data_reg;

endmodule : fls_query

// ---- fls_query_test.sv ----
`timescale 1ns/100ps
module fls_query_test;
  typedef struct packed {
    logic [1:0]  ctrl;
    logic [3:0]  sw;
    logic [7:0]  ss;
    logic [3:0]  ph;
    logic [3:0]  lg;
    logic [3:0]  aw;
    logic [7:0]  sp;
    logic [47:0] ex;
  } fls_row_s;
  logic        CLK_SYS, RST_N, RQ_VALID, RQ_LAST, RQ_CSUM_ERR, RQ_ID_ERR, RQ_READY;
  logic        RS_VALID, RS_LAST, RS_READY, WR_STB, RD_STB;
  logic [7:0]  RQ_DATA, RS_DATA, RS_TYPE, ADDR, ACT_SPEED_GRADE;
  logic [5:0]  RS_INDEX;
  logic [3:0]  PHYS_STATE, LOG_STATE, ACT_LANE_WIDTH;
  logic [31:0] WR_DATA, RD_DATA;
  int          bad_count, total_checks;
  // Expected bytes 28, 29, 30, 31, 33 and 35 packed high to low.
  fls_row_s rows [6] = '{
    '{2'h3, 4'hF, 8'hFF, 4'h5, 4'h4, 4'h4, 8'h10, 48'h040F015410FF},
    '{2'h3, 4'h5, 8'h21, 4'h2, 4'h1, 4'h2, 8'h04, 48'h000501210021},
    '{2'h2, 4'hF, 8'hFF, 4'h5, 4'h4, 4'h1, 8'h01, 48'h000000000000},
    '{2'h3, 4'hA, 8'h80, 4'h7, 4'h3, 4'h8, 8'h80, 48'h000A01730080},
    '{2'h3, 4'h1, 8'h81, 4'h5, 4'h2, 4'h1, 8'h80, 48'h010101528081},
    '{2'h3, 4'h3, 8'h0F, 4'h9, 4'h6, 4'h2, 8'h02, 48'h00030100000F}};
  fls_query #(.REQ_LEN(46)) i_fls_query (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .RQ_VALID(RQ_VALID), .RQ_DATA(RQ_DATA),
    .RQ_LAST(RQ_LAST), .RQ_CSUM_ERR(RQ_CSUM_ERR), .RQ_ID_ERR(RQ_ID_ERR),
    .RQ_READY(RQ_READY), .RS_VALID(RS_VALID), .RS_DATA(RS_DATA), .RS_INDEX(RS_INDEX),
    .RS_LAST(RS_LAST), .RS_TYPE(RS_TYPE), .RS_READY(RS_READY), .PHYS_STATE(PHYS_STATE),
    .LOG_STATE(LOG_STATE), .ACT_LANE_WIDTH(ACT_LANE_WIDTH),
    .ACT_SPEED_GRADE(ACT_SPEED_GRADE), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .RD_DATA(RD_DATA));
  fls_mc_model #(.REQ_LEN(46)) i_fls_mc_model (
    .CLK_SYS(CLK_SYS), .RQ_READY(RQ_READY), .RS_VALID(RS_VALID), .RS_DATA(RS_DATA),
    .RS_INDEX(RS_INDEX), .RQ_VALID(RQ_VALID), .RQ_DATA(RQ_DATA), .RQ_LAST(RQ_LAST),
    .RQ_CSUM_ERR(RQ_CSUM_ERR), .RQ_ID_ERR(RQ_ID_ERR), .RS_READY(RS_READY));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_byte(input logic [47:0] e, input int idx);
    case (idx)
      28: return e[47:40];
      29: return e[39:32];
      30: return e[31:24];
      31: return e[23:16];
      33: return e[15:8];
      35: return e[7:0];
      default: return 8'h00;
    endcase
  endfunction : exp_byte
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    #1 check(RD_DATA, exp);
  endtask : reg_rd
  // The wait is bounded because a lost reply would otherwise hang the run.
  task automatic wait_reply;
    int w;
    w = 0;
    while (i_fls_mc_model.n < 20 && w < 300) begin
      @(posedge CLK_SYS);
      w++;
    end
    if (i_fls_mc_model.n < 20) begin
      bad_count++;
      end_of_test;
    end
    @(posedge CLK_SYS);
  endtask : wait_reply
  task automatic quiet(input logic [7:0] t, input logic c, input logic d);
    @(posedge CLK_SYS);
    i_fls_mc_model.send(t, c, d);
    repeat (4) @(posedge CLK_SYS);
    #1 check(i_fls_mc_model.n, 0);
  endtask : quiet
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    {RST_N, WR_STB, RD_STB, ADDR, WR_DATA} = '0;
    {PHYS_STATE, LOG_STATE, ACT_LANE_WIDTH, ACT_SPEED_GRADE} = '0;
    repeat (16) @(posedge CLK_SYS);
    #1 check({7'h00, RQ_READY, RS_VALID, RS_LAST, RS_INDEX, RS_DATA, RS_TYPE}, 32'h0110_0000);
    check(RD_DATA, 32'h0);
    @(posedge CLK_SYS);
    RST_N <= 1'b1;
    reg_rd(fls_pkg::ADDR_CTRL, 32'h2);
    reg_rd(fls_pkg::ADDR_SUP_WIDTH, 32'hF);
    reg_rd(fls_pkg::ADDR_SUP_SPEED, 32'hFF);
    reg_rd(8'h14, 32'h0);
    $display("reset test done");
    for (int r = 0; r < 6; r++) begin
      reg_wr(fls_pkg::ADDR_CTRL, 32'(rows[r].ctrl));
      reg_wr(fls_pkg::ADDR_SUP_WIDTH, 32'(rows[r].sw));
      reg_wr(fls_pkg::ADDR_SUP_SPEED, 32'(rows[r].ss));
      {PHYS_STATE, LOG_STATE, ACT_LANE_WIDTH} <= {rows[r].ph, rows[r].lg, rows[r].aw};
      ACT_SPEED_GRADE <= rows[r].sp;
      i_fls_mc_model.slow = r[0];
      i_fls_mc_model.send(8'h38, 1'b0, 1'b0);
      wait_reply;
      for (int k = 16; k < 36; k++) begin
        check(i_fls_mc_model.rsp[k], exp_byte(rows[r].ex, k));
      end
      check({i_fls_mc_model.hung, RS_TYPE}, 9'h0B8);
      $display("query row %0d done", r);
    end
    reg_rd(fls_pkg::ADDR_COUNTS, 32'h6);
    reg_wr(fls_pkg::ADDR_COUNTS, 32'h0);
    quiet(8'h38, 1'b1, 1'b0);
    quiet(8'h38, 1'b0, 1'b1);
    quiet(8'h39, 1'b0, 1'b0);
    reg_wr(fls_pkg::ADDR_CTRL, 32'h1);
    quiet(8'h38, 1'b0, 1'b0);
    reg_rd(fls_pkg::ADDR_COUNTS, 32'h02010100);
    reg_rd(fls_pkg::ADDR_STATUS, 32'h3800);
    $display("refusal test done");
    reg_wr(fls_pkg::ADDR_CTRL, 32'h3);
    i_fls_mc_model.send(8'h38, 1'b0, 1'b0);
    reg_rd(fls_pkg::ADDR_STATUS, 32'h3801);
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1 check({7'h00, RQ_READY, RS_VALID, RS_LAST, RS_INDEX, RS_DATA, RS_TYPE}, 32'h0110_0000);
    check(RD_DATA, 32'h0);
    @(posedge CLK_SYS);
    RST_N <= 1'b1;
    reg_rd(fls_pkg::ADDR_COUNTS, 32'h0);
    reg_rd(fls_pkg::ADDR_CTRL, 32'h2);
    $display("reset in reply done");
    end_of_test;
  end
endmodule : fls_query_test
